//--- gst_cfg.svh
`ifndef GST_CFG_SVH
`define GST_CFG_SVH
// register byte addresses (printed offsets, not all multiples of four -> index*4)
`define GST_IDX_COUNT      12'h20c
`define GST_IDX_CONTROL    12'h20e
`define GST_IDX_GATE_CTRL  12'h20f
`define GST_IDX_GATE_SEL   12'h210
`define GST_IDX_CLK_SEL    12'h211
`define GST_IDX_STATUS     12'h212
`define GST_IDX_IRQ_CTRL   12'h213
// control fields
`define GST_CTL_ON         0
`define GST_CTL_WIDE       1
`define GST_CTL_SYNC       2
`define GST_CTL_PS_LO      4
// gate control fields
`define GST_GC_LEVEL       2
`define GST_GC_GO          3
`define GST_GC_SPM         4
`define GST_GC_TOGGLE      5
`define GST_GC_POL         6
`define GST_GC_EN          7
// status / irq fields
`define GST_ST_OVF         0
`define GST_ST_GATE        1
`define GST_IE_OVF         0
`define GST_IE_GLOBAL      1
// reset values
`define GST_RST_CONTROL    8'h00
`define GST_RST_GATE_CTRL  8'h00
`define GST_RST_SEL        5'h00
`define GST_RST_COUNT      16'h0000
// clock select codes and gate select limit
`define GST_CS_PIN         5'h00
`define GST_CS_FOSC4       5'h01
`define GST_CS_FOSC        5'h02
`define GST_CS_LAST        5'h08
`define GST_GS_LAST        5'h06
// system clock divided by four
`define GST_FOSC4_DIV      2'h3
`endif

//--- gst_pkg.sv
package gst_pkg;
   // apb slave request and answer
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } gst_apb_req_t;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } gst_apb_rsp_t;

   // gate source candidates, index = gate select code
   typedef struct packed {
      logic pwm4;
      logic pwm3;
      logic ccp2;
      logic ccp1;
      logic tmr2;
      logic tmr0;
      logic pin;
   } gst_gate_src_t;

   // clock source candidates, index = clock select code
   typedef struct packed {
      logic tmr0;
      logic mf32k;
      logic mf500k;
      logic sf1m;
      logic lfint;
      logic hfint;
      logic fosc;
      logic fosc4;
      logic pin;
   } gst_clk_src_t;

   typedef enum logic [1:0] {
      GST_PH_IDLE,
      GST_PH_ACCESS
   } gst_phase_t;
endpackage : gst_pkg

//--- gst_timer.sv
`include "gst_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module gst_timer (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire gst_pkg::gst_apb_req_t apb_req,
   output var  gst_pkg::gst_apb_rsp_t apb_rsp,
   input  wire gst_pkg::gst_clk_src_t clk_src,
   input  wire gst_pkg::gst_gate_src_t gate_src,
   input  wire logic                  sleep_mode,
   input  wire logic                  special_trigger,
   output logic [15:0]                count_value,
   output logic                       overflow_irq,
   output logic                       wake_request,
   output logic                       gate_event_irq
);
   // whole state of the block
   typedef struct packed {
      gst_pkg::gst_apb_rsp_t rsp;
      gst_pkg::gst_phase_t   ph;
      logic [15:0] cnt;
      logic [7:0]  hbuf;
      logic [7:0]  ctl;
      logic [7:0]  gctl;
      logic [4:0]  gsel;
      logic [4:0]  csel;
      logic        ovf;
      logic        gflag;
      logic        ie_ovf;
      logic        ie_glob;
      logic [2:0]  psc;
      logic [1:0]  div4;
      logic [1:0]  ck_s1;
      logic [1:0]  ck_s2;
      logic        ck_prev;
      logic        g_s1;
      logic        g_s2;
      logic        g_prev;
      logic        tog;
      logic        gating_level_prev;
      logic        spm_seen;
      logic        irq;
      logic        wake;
      logic        girq;
   } gst_state_t;

   gst_state_t s_q;
   gst_state_t s_d;

   logic [11:0] addr;
   logic        acc_done;
   logic        wr;
   logic        rd;
   logic [7:0]  wb;
   logic        raw_clk;
   logic        ext_clk;
   logic        clk_tick;
   logic        sys_clk;
   logic        gate_raw;
   logic        gate_lvl;
   logic        gate_ok;
   logic        pre_tick;
   logic        inc;
   logic        wr_cnt;
   logic [7:0]  rdat;
   logic        sel_pin;
   logic        use_sync;
   logic        mapped;

   assign addr     = apb_req.paddr;
   assign acc_done = apb_req.psel && apb_req.penable && (s_q.ph == gst_pkg::GST_PH_ACCESS);
   assign wr       = acc_done && apb_req.pwrite;
   assign rd       = acc_done && !apb_req.pwrite;
   assign wb       = apb_req.pwdata[7:0];
   // aligned word inside the register window
   assign mapped   = (addr >= (`GST_IDX_COUNT << 2)) && (addr <= (`GST_IDX_IRQ_CTRL << 2)) && (addr[1:0] == 2'h0);

   // clock source mux and edge detection
   always_comb begin
      raw_clk = 1'b0;
      if (s_q.csel <= `GST_CS_LAST) begin
         raw_clk = s_q.ck_s2[0];
      end
      sys_clk = (s_q.csel == `GST_CS_FOSC) || (s_q.csel == `GST_CS_FOSC4);
      sel_pin = (s_q.csel == `GST_CS_PIN);
      use_sync = !s_q.ctl[`GST_CTL_SYNC] && !sys_clk;
      ext_clk  = use_sync ? s_q.ck_s2[1] : raw_clk;
      if (s_q.csel == `GST_CS_FOSC) begin
         clk_tick = 1'b1;
      end else if (s_q.csel == `GST_CS_FOSC4) begin
         clk_tick = (s_q.div4 == `GST_FOSC4_DIV);
      end else begin
         clk_tick = ext_clk && !s_q.ck_prev;
      end
   end

   // gate path: select, toggle, polarity, single pulse
   always_comb begin
      gate_raw = 1'b0;
      if (s_q.gsel <= `GST_GS_LAST) begin
         gate_raw = s_q.g_s2;
      end
      gate_lvl = s_q.gctl[`GST_GC_TOGGLE] ? s_q.tog : gate_raw;
      gate_lvl = s_q.gctl[`GST_GC_POL] ? gate_lvl : !gate_lvl;
      gate_ok = gate_lvl;
      if (s_q.gctl[`GST_GC_SPM]) begin
         gate_ok = gate_lvl && s_q.gctl[`GST_GC_GO] && s_q.spm_seen;
      end
      if (!s_q.gctl[`GST_GC_EN]) begin
         gate_ok = 1'b1;
      end
      // sleep stops synced and system clocked counting
      if (sleep_mode && (use_sync || sys_clk)) begin
         gate_ok = 1'b0;
      end
   end

   // prescaler tick and counter increment
   always_comb begin
      case (s_q.ctl[`GST_CTL_PS_LO +: 2])
         2'h0: pre_tick = 1'b1;
         2'h1: pre_tick = s_q.psc[0];
         2'h2: pre_tick = &s_q.psc[1:0];
         default: pre_tick = &s_q.psc;
      endcase
      inc = s_q.ctl[`GST_CTL_ON] && gate_ok && clk_tick && pre_tick;
   end

   // read mux
   always_comb begin
      rdat = 8'h00;
      if (addr == (`GST_IDX_COUNT << 2)) begin
         rdat = s_q.cnt[7:0];
      end else if (addr == ((`GST_IDX_COUNT + 12'h001) << 2)) begin
         // buffered high byte in wide mode
         rdat = s_q.ctl[`GST_CTL_WIDE] ? s_q.hbuf : s_q.cnt[15:8];
      end else if (addr == (`GST_IDX_CONTROL << 2)) begin
         rdat = s_q.ctl & 8'h37;
      end else if (addr == (`GST_IDX_GATE_CTRL << 2)) begin
         rdat = {s_q.gctl[7:3], gate_lvl, 2'h0};
      end else if (addr == (`GST_IDX_GATE_SEL << 2)) begin
         rdat = {3'h0, s_q.gsel};
      end else if (addr == (`GST_IDX_CLK_SEL << 2)) begin
         rdat = {3'h0, s_q.csel};
      end else if (addr == (`GST_IDX_STATUS << 2)) begin
         rdat = {6'h00, s_q.gflag, s_q.ovf};
      end else if (addr == (`GST_IDX_IRQ_CTRL << 2)) begin
         rdat = {6'h00, s_q.ie_glob, s_q.ie_ovf};
      end
   end

   // next state
   always_comb begin
      s_d = s_q;
      wr_cnt = 1'b0;
      // synchronisers: clock bit0 raw sample path, bit1 sync path
      s_d.ck_s1 = {clk_src[s_q.csel[3:0]], clk_src[s_q.csel[3:0]]};
      s_d.ck_s2 = s_q.ck_s1;
      s_d.g_s1  = gate_src[s_q.gsel[2:0]];
      s_d.g_s2  = s_q.g_s1;
      s_d.ck_prev = ext_clk;
      s_d.div4  = s_q.div4 + 2'h1;
      s_d.g_prev = gate_raw;
      // toggle on rising gate, cleared when off
      if (!s_q.gctl[`GST_GC_TOGGLE]) begin
         s_d.tog = 1'b0;
      end else if (gate_raw && !s_q.g_prev) begin
         s_d.tog = !s_q.tog;
      end
      s_d.gating_level_prev = gate_lvl;
      // single pulse: first incrementing edge arms counting
      if (s_q.gctl[`GST_GC_GO] && gate_lvl && clk_tick) begin
         s_d.spm_seen = 1'b1;
      end
      if (s_q.gctl[`GST_GC_SPM] && s_q.gctl[`GST_GC_GO] && s_q.spm_seen && !gate_lvl) begin
         s_d.gctl[`GST_GC_GO] = 1'b0;
         s_d.spm_seen = 1'b0;
      end
      if (special_trigger) begin
         s_d.cnt = 16'h0000;
      end else if (inc) begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end
      if (clk_tick && s_q.ctl[`GST_CTL_ON] && gate_ok) begin
         s_d.psc = s_q.psc + 3'h1;
      end
      // apb handshake
      s_d.rsp.pready  = 1'b0;
      s_d.rsp.pslverr = 1'b0;
      if (apb_req.psel && !apb_req.penable) begin
         s_d.ph = gst_pkg::GST_PH_ACCESS;
         s_d.rsp.pready = 1'b1;
         // answer stands together with pready in the access cycle
         s_d.rsp.prdata  = apb_req.pwrite ? 32'h0 : {24'h000000, rdat};
         s_d.rsp.pslverr = !mapped;
      end else begin
         s_d.ph = gst_pkg::GST_PH_IDLE;
      end
      if (rd) begin
         if (addr == (`GST_IDX_COUNT << 2) && s_q.ctl[`GST_CTL_WIDE]) begin
            s_d.hbuf = s_q.cnt[15:8];
         end
      end
      if (wr) begin
         if (addr == (`GST_IDX_COUNT << 2)) begin
            wr_cnt = 1'b1;
            // wide write takes buffered high byte
            if (s_q.ctl[`GST_CTL_WIDE]) begin
               s_d.cnt = {s_q.hbuf, wb};
            end else begin
               s_d.cnt = {s_d.cnt[15:8], wb};
            end
         end else if (addr == ((`GST_IDX_COUNT + 12'h001) << 2)) begin
            wr_cnt = 1'b1;
            if (s_q.ctl[`GST_CTL_WIDE]) begin
               s_d.hbuf = wb;
            end else begin
               s_d.cnt = {wb, s_d.cnt[7:0]};
            end
         end else if (addr == (`GST_IDX_CONTROL << 2)) begin
            s_d.ctl = wb & 8'h37;
         end else if (addr == (`GST_IDX_GATE_CTRL << 2)) begin
            s_d.gctl = {wb[7:3], 3'h0};
            if (wb[`GST_GC_GO] && !s_q.gctl[`GST_GC_GO]) begin
               s_d.spm_seen = 1'b0;
            end
         end else if (addr == (`GST_IDX_GATE_SEL << 2)) begin
            s_d.gsel = wb[4:0];
         end else if (addr == (`GST_IDX_CLK_SEL << 2)) begin
            s_d.csel = wb[4:0];
         end else if (addr == (`GST_IDX_STATUS << 2)) begin
            s_d.ovf   = s_q.ovf & wb[`GST_ST_OVF];
            s_d.gflag = s_q.gflag & wb[`GST_ST_GATE];
         end else if (addr == (`GST_IDX_IRQ_CTRL << 2)) begin
            s_d.ie_ovf  = wb[`GST_IE_OVF];
            s_d.ie_glob = wb[`GST_IE_GLOBAL];
         end
      end
      if (wr_cnt) begin
         s_d.psc = 3'h0;
      end
      // go clears when single pulse disabled
      if (!s_d.gctl[`GST_GC_SPM]) begin
         s_d.gctl[`GST_GC_GO] = 1'b0;
      end
      if (inc && !special_trigger && !wr_cnt && s_q.cnt == 16'hffff) begin
         s_d.ovf = 1'b1;
      end
      // falling gate level sets gate flag
      if (s_q.gating_level_prev && !gate_lvl) begin
         s_d.gflag = 1'b1;
      end
      s_d.irq = s_d.ovf && s_d.ie_ovf && s_d.ie_glob && s_d.ctl[`GST_CTL_ON];
      // wake on enabled overflow in sleep
      s_d.wake = sleep_mode && s_d.ovf && s_d.ie_ovf && s_d.ctl[`GST_CTL_ON];
      s_d.girq = s_d.gflag;
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.ctl  <= `GST_RST_CONTROL;
         s_q.gctl <= `GST_RST_GATE_CTRL;
         s_q.gsel <= `GST_RST_SEL;
         s_q.csel <= `GST_RST_SEL;
         s_q.cnt  <= `GST_RST_COUNT;
      end else begin
         s_q <= s_d;
      end
   end

   assign count_value    = s_q.cnt;
   assign apb_rsp        = s_q.rsp;
   assign overflow_irq   = s_q.irq;
   assign wake_request   = s_q.wake;
   assign gate_event_irq = s_q.girq;
endmodule : gst_timer
`default_nettype wire

//--- gst_timer_checker.sv
`timescale 1ns/1ps
`default_nettype none
module gst_timer_checker (
   input wire logic                   clk,
   input wire logic                   rst,
   input wire gst_pkg::gst_apb_req_t  apb_req,
   input wire gst_pkg::gst_apb_rsp_t  apb_rsp,
   input wire gst_pkg::gst_clk_src_t  clk_src,
   input wire gst_pkg::gst_gate_src_t gate_src,
   input wire logic                   sleep_mode,
   input wire logic                   special_trigger,
   input wire logic [15:0]            count_value,
   input wire logic                   overflow_irq,
   input wire logic                   wake_request,
   input wire logic                   gate_event_irq
);
   logic [2:0] wr_q;
   // counter write access and mapped addresses
   wire logic cwr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr[11:3] == 9'h106;
   wire logic mapped = apb_req.paddr inside {12'h830, 12'h834, 12'h838, 12'h83c, 12'h840, 12'h844, 12'h848, 12'h84c};
   // history of counter writes
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q <= 3'h0;
      end else begin
         wr_q <= {wr_q[1:0], cwr};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_reset_clear:
      assert property (disable iff (1'b0) rst |=> count_value == 16'h0 && !overflow_irq && !wake_request)
      else $error("outputs not cleared by reset");
   a_ready_zero:
      assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready) else $error("no zero wait answer");
   a_ready_pulse:
      assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pready held");
   a_ready_access:
      assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable) else $error("pready outside access");
   a_unmapped_err:
      assert property (apb_rsp.pready |-> apb_rsp.pslverr == !mapped) else $error("wrong slave error");
   a_err_read_zero:
      assert property (apb_rsp.pslverr && !apb_req.pwrite |-> apb_rsp.prdata == 32'h0) else $error("refused read data");
   a_trig_clear:
      assert property ((special_trigger && !cwr) [*4] |-> count_value == 16'h0) else $error("trigger left count");
   a_count_step:
      assert property (disable iff (rst || cwr || |wr_q)
         $changed(count_value) |-> count_value == $past(count_value) + 16'h1 || count_value == 16'h0)
      else $error("count jumped");
   a_wake_sleep:
      assert property (wake_request |-> $past(sleep_mode) || $past(sleep_mode, 2)) else $error("wake while awake");
endmodule : gst_timer_checker
bind gst_timer gst_timer_checker i_gst_timer_checker (.clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .clk_src(clk_src), .gate_src(gate_src), .sleep_mode(sleep_mode), .special_trigger(special_trigger),
   .count_value(count_value), .overflow_irq(overflow_irq), .wake_request(wake_request), .gate_event_irq(gate_event_irq));
`default_nettype wire

//--- gst_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module gst_far_side (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   gate_lvl,
   output var  gst_pkg::gst_clk_src_t  clk_src,
   output var  gst_pkg::gst_gate_src_t gate_src
);
   logic [3:0] div_q;
   // free running divider for the outside clocks
   always_ff @(posedge clk) begin
      if (rst) begin
         div_q <= 4'h0;
      end else begin
         div_q <= div_q + 4'h1;
      end
   end
   // pin clock has an 8 cycle period, pin gate follows the bench
   assign clk_src  = {div_q[3], div_q[2], div_q[3], div_q[1], div_q[3], div_q[2], div_q[0], div_q[1], div_q[2]};
   assign gate_src = {div_q[3], div_q[2], div_q[3], div_q[2], div_q[3], div_q[3], gate_lvl};
endmodule : gst_far_side
`default_nettype wire

//--- gst_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
module gst_timer_test;
   typedef struct {logic [11:0] a; logic [7:0] d;} gst_row_t;
   logic                   clk = 1'b0;
   logic                   rst = 1'b1;
   logic                   sleep_mode = 1'b0;
   logic                   special_trigger = 1'b0;
   logic                   gate_lvl = 1'b0;
   gst_pkg::gst_apb_req_t  apb_req = '0;
   gst_pkg::gst_apb_rsp_t  apb_rsp;
   gst_pkg::gst_clk_src_t  clk_src;
   gst_pkg::gst_gate_src_t gate_src;
   logic [15:0]            count_value, cv;
   logic                   overflow_irq, wake_request, gate_event_irq, err;
   logic [31:0]            rd;
   int                     mismatches = 0, num_checks = 0, v;
   gst_row_t rows [6] = '{'{12'h830, 8'h5a}, '{12'h834, 8'ha5}, '{12'h838, 8'h36},
                          '{12'h840, 8'h06}, '{12'h844, 8'h08}, '{12'h84c, 8'h02}};
   // clock
   always #4 clk = ~clk;
   // timer and its sources
   gst_timer i_gst_timer (.clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp), .clk_src(clk_src),
      .gate_src(gate_src), .sleep_mode(sleep_mode), .special_trigger(special_trigger), .count_value(count_value),
      .overflow_irq(overflow_irq), .wake_request(wake_request), .gate_event_irq(gate_event_irq));
   gst_far_side i_gst_far_side (.clk(clk), .rst(rst), .gate_lvl(gate_lvl), .clk_src(clk_src), .gate_src(gate_src));
   task automatic stop_test;
      $display("mismatches %0d checks %0d", mismatches, num_checks);
      if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         $display("BAD %0t got %h exp %h", $time, g, e);
         mismatches++;
      end
   endtask : chk
   // one apb transfer, optional trigger in the access cycle
   task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d, input logic tw);
      int k;
      @(posedge clk);
      apb_req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      if (tw) special_trigger <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (apb_rsp.pready === 1'b1) break;
      end
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
      if (tw) special_trigger <= 1'b0;
      if (k == 20) begin
         mismatches++;
         stop_test();
      end
   endtask : xfer
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, a, d, 1'b0);
   endtask : wr
   task automatic rdr(input logic [11:0] a);
      xfer(1'b0, a, 8'h00, 1'b0);
   endtask : rdr
   task automatic waitfor(ref logic s);
      int k;
      for (k = 0; k < 300 && s !== 1'b1; k++) @(posedge clk);
      if (k == 300) begin
         mismatches++;
         stop_test();
      end
   endtask : waitfor
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         rdr(rows[i].a);
         chk(rd, 32'h0);
         wr(rows[i].a, rows[i].d);
         rdr(rows[i].a);
         chk(rd, {24'h0, rows[i].d});
      end
      for (v = 0; v < 9; v++) begin
         wr(12'h844, v[7:0]);
         rdr(12'h844);
         chk(rd, v);
         wr(12'h840, 8'(v % 7));
         rdr(12'h840);
         chk(rd, v % 7);
      end
      rdr(12'h850);
      chk(err, 1);
      // wide access
      wr(12'h838, 8'h02);
      wr(12'h834, 8'h12);
      wr(12'h830, 8'h34);
      wr(12'h834, 8'h77);
      repeat (3) @(posedge clk);
      chk(count_value, 16'h1234);
      rdr(12'h830);
      rdr(12'h834);
      chk(rd, 32'h12);
      // overflow, flag first, request once global is on
      wr(12'h838, 8'h00);
      wr(12'h844, 8'h02);
      wr(12'h830, 8'hf0);
      wr(12'h834, 8'hff);
      wr(12'h848, 8'h00);
      wr(12'h84c, 8'h01);
      wr(12'h838, 8'h01);
      repeat (40) @(posedge clk);
      chk(count_value < 16'h0040, 1);
      chk(overflow_irq, 0);
      rdr(12'h848);
      chk(rd[0], 1);
      wr(12'h84c, 8'h03);
      repeat (3) @(posedge clk);
      chk(overflow_irq, 1);
      wr(12'h848, 8'h02);
      repeat (3) @(posedge clk);
      chk(overflow_irq, 0);
      // special trigger holds count at zero, write beats it
      wr(12'h838, 8'h00);
      wr(12'h844, 8'h01);
      wr(12'h830, 8'hf8);
      wr(12'h834, 8'hff);
      wr(12'h848, 8'h00);
      special_trigger <= 1'b1;
      wr(12'h838, 8'h01);
      repeat (40) @(posedge clk);
      chk(count_value, 16'h0);
      rdr(12'h848);
      chk(rd[0], 0);
      special_trigger <= 1'b0;
      wr(12'h838, 8'h00);
      xfer(1'b1, 12'h830, 8'h40, 1'b1);
      repeat (3) @(posedge clk);
      chk(count_value, 16'h0040);
      // prescaler ratios
      wr(12'h844, 8'h02);
      for (v = 0; v < 4; v++) begin
         wr(12'h830, 8'h00);
         wr(12'h834, 8'h00);
         wr(12'h838, 8'(v * 16 + 1));
         repeat (64) @(posedge clk);
         wr(12'h838, 8'(v * 16));
         chk(count_value >= (60 >> v) && count_value <= (70 >> v) + 1, 1);
      end
      // gate enable with active high gate
      wr(12'h838, 8'h00);
      wr(12'h830, 8'h00);
      wr(12'h840, 8'h00);
      wr(12'h83c, 8'hc0);
      wr(12'h848, 8'h00);
      wr(12'h838, 8'h01);
      repeat (20) @(posedge clk);
      chk(count_value, 16'h0);
      gate_lvl <= 1'b1;
      repeat (20) @(posedge clk);
      rdr(12'h83c);
      chk(rd[2], 1);
      gate_lvl <= 1'b0;
      repeat (6) @(posedge clk);
      cv = count_value;
      chk(cv > 16'd10, 1);
      waitfor(gate_event_irq);
      chk(gate_event_irq, 1);
      chk(count_value, cv);
      wr(12'h83c, 8'hd8);
      rdr(12'h83c);
      chk(rd[3], 1);
      wr(12'h83c, 8'hc8);
      rdr(12'h83c);
      chk(rd[3], 0);
      // sleep: unsynchronised pin clock wakes, system clock stops
      wr(12'h838, 8'h00);
      wr(12'h83c, 8'h00);
      wr(12'h844, 8'h00);
      wr(12'h830, 8'hfc);
      wr(12'h834, 8'hff);
      wr(12'h848, 8'h00);
      wr(12'h84c, 8'h01);
      wr(12'h838, 8'h05);
      sleep_mode <= 1'b1;
      waitfor(wake_request);
      chk(wake_request, 1);
      wr(12'h844, 8'h02);
      cv = count_value;
      repeat (20) @(posedge clk);
      chk(count_value, cv);
      // second reset
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk(count_value, 16'h0);
      stop_test();
   end
endmodule : gst_timer_test
`default_nettype wire
